/* File: common/smcu_regs.svh */
// constants for the serial monitor command unit
`ifndef SMCU_REGS_SVH
`define SMCU_REGS_SVH
`define SMCU_OP_READ        8'h4a
`define SMCU_OP_WRITE       8'h49
`define SMCU_OP_IDX_RD      8'h1a
`define SMCU_OP_IDX_WR      8'h19
`define SMCU_OP_RUN         8'h28
`define SMCU_OP_STACK_RD    8'h0c
`define SMCU_SEC_BYTES      4'h8
`define SMCU_SEC_BASE       16'hfff6
`define SMCU_SEC_FLAG_ADDR  16'h0060
`define SMCU_SEC_FLAG_BIT   6
`define SMCU_ERASED         8'hff
`define SMCU_INVALID        8'had
`define SMCU_PROT_LO        16'h8000
`define SMCU_CLK_HZ         125000000
`define SMCU_BAUD           9600
`define SMCU_BIT_CYC        (`SMCU_CLK_HZ / `SMCU_BAUD)
`define SMCU_BRK_BITS       4'h9
`define SMCU_BRK_WAIT_BITS  2
`endif

/* File: common/smcu_pkg.sv */
// types for the serial monitor command unit
package smcu_pkg;
   typedef enum logic [3:0]
   {
      ST_SEC     = 4'h0,
      ST_SECRD   = 4'h1,
      ST_BREAK   = 4'h2,
      ST_IDLE    = 4'h3,
      ST_ADDRH   = 4'h4,
      ST_ADDRL   = 4'h5,
      ST_DATA    = 4'h6,
      ST_MEM     = 4'h7,
      ST_RESULT  = 4'h8,
      ST_ECHOBRK = 4'h9
   } smcu_state_t;
endpackage

/* File: verilog/smcu_uart.sv */
// nrz byte transmitter and receiver with break detection
`timescale 1ns/1ps
`include "smcu_regs.svh"
module smcu_uart #(
   parameter int BIT_CYC = `SMCU_BIT_CYC
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       rxPin,
   output logic            txPin,
   output logic            rxValid,
   output logic [7:0]      rxData,
   output logic            rxBreak,
   input  wire logic       txStart,
   input  wire logic       txBreak,
   input  wire logic [7:0] txData,
   output logic            txBusy
);
   localparam int CW = $clog2(BIT_CYC + 1);
   logic [CW-1:0] rxCnt_reg, rxCnt_next, txCnt_reg, txCnt_next;
   logic [3:0]    rxBit_reg, rxBit_next, txBit_reg, txBit_next;
   logic [8:0]    rxSh_reg, rxSh_next;
   logic          rxAct_reg, rxAct_next;
   logic [9:0]    txSh_reg, txSh_next;
   logic          txAct_reg, txAct_next;
   logic          rxValid_next, rxBreak_next;
   logic [7:0]    rxData_next;

   ////////////////////////////////////////////////////////////////////////////
   // receiver: sample mid bit, 8 data bits plus stop
   always_comb
   begin
      rxCnt_next   = rxCnt_reg;
      rxBit_next   = rxBit_reg;
      rxSh_next    = rxSh_reg;
      rxAct_next   = rxAct_reg;
      rxValid_next = 1'b0;
      rxBreak_next = 1'b0;
      rxData_next  = rxData;
      if (!rxAct_reg)
      begin
         if (!rxPin)
         begin
            rxAct_next = 1'b1;
            rxCnt_next = CW'(BIT_CYC / 2);
            rxBit_next = 4'h0;
         end
      end
      else if (rxCnt_reg != '0)
         rxCnt_next = rxCnt_reg - 1'b1;
      else
      begin
         rxCnt_next = CW'(BIT_CYC - 1);
         if (rxBit_reg != 4'h0)
            rxSh_next = {rxPin, rxSh_reg[8:1]};
         rxBit_next = rxBit_reg + 4'h1;
         if (rxBit_reg == 4'h9)
         begin
            rxAct_next = 1'b0;
            if (rxSh_next == 9'h000)
               rxBreak_next = 1'b1; // RL15
            else
            begin
               rxValid_next = 1'b1;
               rxData_next  = rxSh_next[7:0];
            end
         end
      end
      if (rxAct_reg && rxBit_reg == 4'h9 && rxCnt_reg == '0 && rxSh_next == 9'h000 && !rxPin)
         rxAct_next = 1'b1;
      if (rxAct_next && rxBit_next == 4'ha)
      begin
         rxAct_next = rxPin ? 1'b0 : 1'b1;
         rxBit_next = 4'ha;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxCnt_reg <= '0;
         rxBit_reg <= 4'h0;
         rxSh_reg  <= 9'h1ff;
         rxAct_reg <= 1'b0;
         rxValid   <= 1'b0;
         rxBreak   <= 1'b0;
         rxData    <= 8'h00;
      end
      else
      begin
         rxCnt_reg <= rxCnt_next;
         rxBit_reg <= rxBit_next;
         rxSh_reg  <= rxSh_next;
         rxAct_reg <= rxAct_next;
         rxValid   <= rxValid_next;
         rxBreak   <= rxBreak_next;
         rxData    <= rxData_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter: start, 8 data lsb first, stop; break is ten lows then stop
   always_comb
   begin
      txCnt_next = txCnt_reg;
      txBit_next = txBit_reg;
      txSh_next  = txSh_reg;
      txAct_next = txAct_reg;
      if (!txAct_reg)
      begin
         if (txStart || txBreak)
         begin
            txAct_next = 1'b1;
            txCnt_next = CW'(BIT_CYC - 1);
            txBit_next = 4'h0;
            txSh_next  = txBreak ? 10'h000 : {1'b1, txData, 1'b0}; // RL16
         end
      end
      else if (txCnt_reg != '0)
         txCnt_next = txCnt_reg - 1'b1;
      else
      begin
         txCnt_next = CW'(BIT_CYC - 1);
         txSh_next  = {1'b1, txSh_reg[9:1]};
         txBit_next = txBit_reg + 4'h1;
         if (txBit_reg == 4'ha)
            txAct_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txCnt_reg <= '0;
         txBit_reg <= 4'h0;
         txSh_reg  <= 10'h3ff;
         txAct_reg <= 1'b0;
      end
      else
      begin
         txCnt_reg <= txCnt_next;
         txBit_reg <= txBit_next;
         txSh_reg  <= txSh_next;
         txAct_reg <= txAct_next;
      end
   end

   assign txPin  = txAct_reg ? txSh_reg[0] : 1'b1;
   assign txBusy = txAct_reg;
endmodule

/* File: verilog/smcu_monitor.sv */
// serial monitor command interpreter with security check
//
// Operation
// [RL1] read opcode, address high then low; device returns the byte stored there
// [RL2] write opcode, address high, low, data; byte stored, nothing returned
// [RL3] indexed read returns next two bytes and advances the pointer past them; the code leaves the pointer on the second byte read
// [RL4] indexed write stores data at last address plus one, nothing returned
// [RL5] indexed commands keep incrementing the 16-bit pointer, wrapping the full space
// [RL6] run opcode echoes only, then leaves the monitor to resume user code
// [RL7] after power-on reset eight received bytes are compared in order with stored bytes
// [RL8] passed security survives every reset except power-on; no new byte request
// [RL9] on failure stay in monitor; protected reads invalid; protected execute resets
// [RL10] break sent only after all eight security bytes, matched or not
// [RL11] on success bit six of ram byte 0x60 is set for the host to read
// [RL12] host retries a failed check only through power-on reset
// [RL13] bulk erase leaves all eight security bytes at 0xff
// [RL14] every received byte is echoed; results follow the last echo; the code echoes no byte received in ST_BREAK
// [RL15] break is start plus nine lows; echoed after two bit times
// [RL16] nrz mark/space framing, same rate both ways, nominally 9600 baud
// [RL17] read stack pointer command returns the stack pointer high then low
`timescale 1ns/1ps
`include "smcu_regs.svh"
module smcu_monitor #(
   parameter int          BIT_CYC     = `SMCU_BIT_CYC,
   parameter logic [7:0]  OP_STACK_RD = `SMCU_OP_STACK_RD
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        porEvent,
   input  wire logic        monitor_rx_pin,
   output logic             monitor_tx_pin,
   output logic             memReq,
   output logic             memWe,
   output logic [15:0]      memAddr,
   output logic [7:0]       memWdata,
   input  wire logic [7:0]  memRdata,
   input  wire logic        memAck,
   input  wire logic [15:0] stackPtr,
   input  wire logic        bulkErase,
   input  wire logic        execFetch,
   input  wire logic [15:0] execAddr,
   output logic             runUser,
   output logic             illegalAddrReset,
   output logic             securityPassed
);
   logic        rxValid, rxBreak, txBusy, txStart, txBreak;
   logic [7:0]  rxData, txData;
   smcu_pkg::smcu_state_t st_reg, st_next;
   logic [7:0]  cmd_reg, cmd_next, data_reg, data_next;
   logic [15:0] ptr_reg, ptr_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic        ok_reg, ok_next, pass_reg, pass_next;
   logic        secAct_reg, secAct_next;
   logic [7:0]  secMem_reg [0:7];
   logic [7:0]  res_reg [0:1];
   logic [7:0]  res_next [0:1];
   logic [1:0]  nres_reg, nres_next;
   logic [15:0] wait_reg, wait_next;
   logic        memReq_next, memWe_next, run_next, ill_next;
   logic [7:0]  rdVal;

   smcu_uart #(.BIT_CYC(BIT_CYC)) uartInst (
      .clock   (clock),
      .rst_n   (rst_n),
      .rxPin   (monitor_rx_pin),
      .txPin   (monitor_tx_pin),
      .rxValid (rxValid),
      .rxData  (rxData),
      .rxBreak (rxBreak),
      .txStart (txStart),
      .txBreak (txBreak),
      .txData  (txData),
      .txBusy  (txBusy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // stored security bytes, erased by bulk erase
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : gSec
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               secMem_reg[gi] <= `SMCU_ERASED;
            else if (bulkErase)
               secMem_reg[gi] <= `SMCU_ERASED; // RL13
            else if (memReq && memWe && memAck && memAddr == `SMCU_SEC_BASE + 16'(gi) && pass_reg)
               secMem_reg[gi] <= memWdata;
         end
      end
   endgenerate

   // protected reads give an invalid value unless security passed
   assign rdVal = (memAddr == `SMCU_SEC_FLAG_ADDR) ? (memRdata | (8'(pass_reg) << `SMCU_SEC_FLAG_BIT)) // RL11
                : (!pass_reg && memAddr >= `SMCU_PROT_LO) ? `SMCU_INVALID : memRdata; // RL9

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_comb
   begin
      st_next     = st_reg;
      cmd_next    = cmd_reg;
      data_next   = data_reg;
      ptr_next    = ptr_reg;
      cnt_next    = cnt_reg;
      ok_next     = ok_reg;
      pass_next   = pass_reg;
      secAct_next = secAct_reg;
      res_next    = res_reg;
      nres_next   = nres_reg;
      wait_next   = wait_reg;
      memReq_next = memReq;
      memWe_next  = memWe;
      run_next    = 1'b0;
      ill_next    = 1'b0;
      txStart     = 1'b0;
      txBreak     = 1'b0;
      txData      = rxData;
      if (execFetch && !pass_reg && execAddr >= `SMCU_PROT_LO)
         ill_next = 1'b1; // RL9
      if (rxValid && st_reg != smcu_pkg::ST_SEC && st_reg != smcu_pkg::ST_BREAK)
         txStart = 1'b1; // RL14
      case (st_reg)
         smcu_pkg::ST_SEC:
            if (rxValid)
            begin
               txStart = 1'b1; // RL14
               if (rxData != secMem_reg[cnt_reg[2:0]])
                  ok_next = 1'b0; // RL7
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == `SMCU_SEC_BYTES - 4'h1)
                  st_next = smcu_pkg::ST_SECRD;
            end
         smcu_pkg::ST_SECRD:
         begin
            pass_next   = ok_reg; // RL11
            secAct_next = 1'b0;
            st_next     = smcu_pkg::ST_BREAK;
         end
         smcu_pkg::ST_BREAK:
            if (!txBusy)
            begin
               txBreak = 1'b1; // RL10
               st_next = smcu_pkg::ST_IDLE;
            end
         smcu_pkg::ST_IDLE:
            if (rxBreak)
            begin
               wait_next = 16'(BIT_CYC * `SMCU_BRK_WAIT_BITS); // RL15
               st_next   = smcu_pkg::ST_ECHOBRK;
            end
            else if (rxValid)
            begin
               cmd_next = rxData;
               case (rxData)
                  `SMCU_OP_READ, `SMCU_OP_WRITE: st_next = smcu_pkg::ST_ADDRH;
                  `SMCU_OP_IDX_WR:               st_next = smcu_pkg::ST_DATA;
                  `SMCU_OP_IDX_RD:
                  begin
                     cnt_next    = 4'h0;
                     nres_next   = 2'h2;
                     ptr_next    = ptr_reg + 16'h0001; // RL3
                     memWe_next  = 1'b0;
                     memReq_next = 1'b1;
                     st_next     = smcu_pkg::ST_MEM;
                  end
                  `SMCU_OP_RUN: run_next = 1'b1; // RL6
                  default:
                     if (rxData == OP_STACK_RD)
                     begin
                        res_next[0] = stackPtr[15:8]; // RL17
                        res_next[1] = stackPtr[7:0];
                        nres_next   = 2'h2;
                        cnt_next    = 4'h0;
                        st_next     = smcu_pkg::ST_RESULT;
                     end
               endcase
            end
         smcu_pkg::ST_ADDRH:
            if (rxValid)
            begin
               ptr_next[15:8] = rxData;
               st_next        = smcu_pkg::ST_ADDRL;
            end
         smcu_pkg::ST_ADDRL:
            if (rxValid)
            begin
               ptr_next[7:0] = rxData;
               if (cmd_reg == `SMCU_OP_READ)
               begin
                  cnt_next    = 4'h0;
                  nres_next   = 2'h1;
                  memWe_next  = 1'b0;
                  memReq_next = 1'b1; // RL1
                  st_next     = smcu_pkg::ST_MEM;
               end
               else
                  st_next = smcu_pkg::ST_DATA;
            end
         smcu_pkg::ST_DATA:
            if (rxValid)
            begin
               data_next = rxData;
               if (cmd_reg == `SMCU_OP_IDX_WR)
                  ptr_next = ptr_reg + 16'h0001; // RL4
               memWe_next  = 1'b1; // RL2
               memReq_next = 1'b1;
               nres_next   = 2'h0;
               st_next     = smcu_pkg::ST_MEM;
            end
         smcu_pkg::ST_MEM:
            if (memAck)
            begin
               memReq_next = 1'b0;
               if (memWe)
                  st_next = smcu_pkg::ST_IDLE;
               else
               begin
                  res_next[cnt_reg[0]] = rdVal;
                  if (cnt_reg == 4'(nres_reg) - 4'h1)
                  begin
                     cnt_next = 4'h0;
                     st_next  = smcu_pkg::ST_RESULT;
                  end
                  else
                  begin
                     cnt_next    = cnt_reg + 4'h1;
                     ptr_next    = ptr_reg + 16'h0001; // RL5
                     memReq_next = 1'b1;
                  end
               end
            end
         smcu_pkg::ST_RESULT:
            if (!txBusy && !rxValid)
            begin
               txStart = 1'b1; // RL14
               txData  = res_reg[cnt_reg[0]];
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == 4'(nres_reg) - 4'h1)
                  st_next = smcu_pkg::ST_IDLE;
            end
         smcu_pkg::ST_ECHOBRK:
            if (wait_reg != 16'h0000)
               wait_next = wait_reg - 16'h0001;
            else if (!txBusy)
            begin
               txBreak = 1'b1; // RL15
               st_next = smcu_pkg::ST_IDLE;
            end
         default: st_next = smcu_pkg::ST_IDLE;
      endcase
      if (secAct_reg && st_reg == smcu_pkg::ST_IDLE && st_next == smcu_pkg::ST_IDLE)
         st_next = smcu_pkg::ST_SEC; // RL7
      if (porEvent)
      begin
         pass_next   = 1'b0; // RL12
         secAct_next = 1'b1;
         ok_next     = 1'b1;
         cnt_next    = 4'h0;
         memReq_next = 1'b0;
         st_next     = smcu_pkg::ST_SEC;
      end
   end

   // pass flag and security request survive rst_n; only porEvent rearms them
   always_ff @(posedge clock)
   begin
      pass_reg   <= pass_next; // RL8
      secAct_reg <= secAct_next;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg   <= smcu_pkg::ST_IDLE;
         cmd_reg  <= 8'h00;
         data_reg <= 8'h00;
         ptr_reg  <= 16'h0000;
         cnt_reg  <= 4'h0;
         ok_reg   <= 1'b1;
         res_reg  <= '{8'h00, 8'h00};
         nres_reg <= 2'h0;
         wait_reg <= 16'h0000;
         memReq   <= 1'b0;
         memWe    <= 1'b0;
         runUser  <= 1'b0;
         illegalAddrReset <= 1'b0;
      end
      else
      begin
         st_reg   <= st_next; // RL8
         cmd_reg  <= cmd_next;
         data_reg <= data_next;
         ptr_reg  <= ptr_next;
         cnt_reg  <= cnt_next;
         ok_reg   <= ok_next;
         res_reg  <= res_next;
         nres_reg <= nres_next;
         wait_reg <= wait_next;
         memReq   <= memReq_next;
         memWe    <= memWe_next;
         runUser  <= run_next;
         illegalAddrReset <= ill_next;
      end
   end

   assign memAddr        = ptr_reg;
   assign memWdata       = data_reg;
   assign securityPassed = pass_reg;
endmodule

/* File: tb/smcu_monitor_assertions.sv */
// concurrent checks on the monitor ports
`timescale 1ns/1ps
module smcu_monitor_assertions #(
   parameter int BIT_CYC = 16
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        monitor_tx_pin,
   input  wire logic        memReq,
   input  wire logic        memWe,
   input  wire logic [15:0] memAddr,
   input  wire logic [7:0]  memWdata,
   input  wire logic        memAck,
   input  wire logic        execFetch,
   input  wire logic [15:0] execAddr,
   input  wire logic        runUser,
   input  wire logic        illegalAddrReset,
   input  wire logic        securityPassed
);
   logic [15:0] lowCnt_reg;
   logic [15:0] lowCnt_next;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // length of the current low stretch on the transmit line
   always_comb lowCnt_next = monitor_tx_pin ? 16'h0000 : lowCnt_reg + 16'h0001;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         lowCnt_reg <= 16'h0000;
      else
         lowCnt_reg <= lowCnt_next;
   property p_reqHold; memReq && !memAck |=> memReq; endproperty
   a_reqHold: assert property (p_reqHold) else $error("memory request dropped before ack");
   property p_reqStable; memReq && !memAck |=> $stable(memAddr) && $stable(memWe) && $stable(memWdata); endproperty
   a_reqStable: assert property (p_reqStable) else $error("memory request changed before ack");
   property p_illegalHit; execFetch && execAddr[15] && !securityPassed |-> ##[0:2] illegalAddrReset; endproperty
   a_illegalHit: assert property (p_illegalHit) else $error("protected fetch without reset");
   property p_illegalCause; illegalAddrReset |-> !securityPassed; endproperty
   a_illegalCause: assert property (p_illegalCause) else $error("reset raised while passed");
   property p_runPulse; runUser |=> !runUser; endproperty
   a_runPulse: assert property (p_runPulse) else $error("run pulse too long");
   property p_txIdle; $rose(rst_n) |-> monitor_tx_pin; endproperty
   a_txIdle: assert property (p_txIdle) else $error("transmit line not idle after reset");
   property p_startBit; $fell(monitor_tx_pin) |-> !monitor_tx_pin [*8]; endproperty
   a_startBit: assert property (p_startBit) else $error("start bit too short");
   property p_breakLen; $rose(monitor_tx_pin) && int'(lowCnt_reg) > 9 * BIT_CYC |-> int'(lowCnt_reg) >= 10 * BIT_CYC; endproperty
   a_breakLen: assert property (p_breakLen) else $error("break shorter than ten bits");
   c_run: cover property (runUser);
   c_illegal: cover property (illegalAddrReset);
   c_write: cover property (memReq && memWe && memAck);
endmodule
bind smcu_monitor smcu_monitor_assertions #(.BIT_CYC(BIT_CYC)) chk_u (.clock(clock), .rst_n(rst_n),
   .monitor_tx_pin(monitor_tx_pin), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
   .memAck(memAck), .execFetch(execFetch), .execAddr(execAddr), .runUser(runUser),
   .illegalAddrReset(illegalAddrReset), .securityPassed(securityPassed));

/* File: tb/smcu_mem_model.sv */
// memory partner model behind the monitor
`timescale 1ns/1ps
module smcu_mem_model (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        memReq,
   input  wire logic        memWe,
   input  wire logic [15:0] memAddr,
   input  wire logic [7:0]  memWdata,
   input  wire logic        bulkErase,
   input  wire logic [3:0]  lat,
   output logic [7:0]       memRdata,
   output logic             memAck
);
   logic [7:0] mem [0:65535];
   logic [3:0] waitCnt;
   ////////////////////////////////////////////////////////////////////////////
   // answers a held request after lat cycles; data toggles while not valid
   always @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         memAck <= 1'b0;
         waitCnt <= 4'h0;
         memRdata <= 8'h00;
      end
      else
      begin
         memAck <= 1'b0;
         memRdata <= ~memRdata;
         if (bulkErase)
            for (int i = 0; i < 8; i++)
               mem[16'hfff6 + 16'(i)] <= 8'hff;
         if (memReq && !memAck && waitCnt >= lat)
         begin
            memAck <= 1'b1;
            waitCnt <= 4'h0;
            memRdata <= mem[memAddr];
            if (memWe)
               mem[memAddr] <= memWdata;
         end
         else if (memReq && !memAck)
            waitCnt <= waitCnt + 4'h1;
      end
endmodule

/* File: tb/smcu_monitor_tb.sv */
// self-checking testbench for the serial monitor
`timescale 1ns/1ps
`include "smcu_regs.svh"
module smcu_monitor_tb;
   localparam int BC = 16;
   logic        clock, rst_n, porEvent, rxPin, txPin, memReq, memWe, memAck, bulkErase, execFetch;
   logic        runUser, illegalAddrReset, securityPassed;
   logic [15:0] memAddr, stackPtr, execAddr;
   logic [7:0]  memWdata, memRdata, d;
   logic [3:0]  lat;
   logic [8:0]  expq[$];
   logic [8:0]  rxw;
   int          seed = 12889;
   int          err_total = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          runCnt = 0;
   int          illCnt = 0;
   smcu_monitor #(.BIT_CYC(BC)) dut_u (.clock(clock), .rst_n(rst_n), .porEvent(porEvent), .monitor_rx_pin(rxPin),
      .monitor_tx_pin(txPin), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .stackPtr(stackPtr), .bulkErase(bulkErase), .execFetch(execFetch),
      .execAddr(execAddr), .runUser(runUser), .illegalAddrReset(illegalAddrReset), .securityPassed(securityPassed));
   smcu_mem_model pm (.clock(clock), .rst_n(rst_n), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memWdata(memWdata), .bulkErase(bulkErase), .lat(lat), .memRdata(memRdata), .memAck(memAck));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [8:0] seen, input logic [8:0] want);
      comparisons++;
      if (seen !== want)
      begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // sends one frame or a break, then waits for all expected bytes
   task automatic hs(input logic [8:0] v);
      expq.push_front(v);
      lat = 4'($random(seed)) & 4'h7;
      rxPin = 1'b0;
      repeat (BC) @(negedge clock);
      for (int i = 0; i < 9; i++)
      begin
         rxPin = v[8] ? 1'b0 : (i < 8 ? v[i] : 1'b1);
         repeat (BC) @(negedge clock);
      end
      rxPin = 1'b1;
      for (int i = 0; i < 2000 && expq.size() != 0; i++)
         @(negedge clock);
      chk(9'(expq.size()), 9'h000);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      hs({1'b0, `SMCU_OP_READ});
      hs({1'b0, a[15:8]});
      expq.push_back({1'b0, e});
      hs({1'b0, a[7:0]});
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      hs({1'b0, `SMCU_OP_WRITE});
      hs({1'b0, a[15:8]});
      hs({1'b0, a[7:0]});
      hs({1'b0, v});
      chk({1'b0, pm.mem[a]}, {1'b0, v});
   endtask
   task automatic secure(input logic bad);
      for (int i = 0; i < 8; i++)
      begin
         if (i == 7)
            expq.push_back(9'h100);
         hs({1'b0, pm.mem[16'hfff6 + 16'(i)] ^ {7'h00, bad && i == 7}});
      end
   endtask
   task automatic por;
      porEvent = 1'b1;
      @(negedge clock);
      porEvent = 1'b0;
   endtask
   task automatic rst;
      rst_n = 1'b0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (BC * 14) @(negedge clock);
   endtask
   task automatic exec(input int want);
      execFetch = 1'b1;
      execAddr = 16'h9000;
      @(negedge clock);
      execFetch = 1'b0;
      repeat (4) @(negedge clock);
      chk(9'(illCnt), 9'(want));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      runCnt += int'(runUser === 1'b1);
      illCnt += int'(illegalAddrReset === 1'b1);
      if (cyc == 60000)
      begin
         err_total++;
         end_sim;
      end
   end
   // decodes every frame on the transmit line against the front of expq
   initial
      forever
      begin
         wait (rst_n === 1'b1 && txPin === 1'b0);
         repeat (BC / 2) @(negedge clock);
         for (int i = 0; i < 9; i++)
         begin
            repeat (BC) @(negedge clock);
            rxw[i] = txPin;
         end
         chk({~rxw[8], rxw[7:0]}, expq.size() != 0 ? expq.pop_front() : 9'h1ff);
         wait (txPin === 1'b1);
      end
   initial
   begin
      {rst_n, porEvent, bulkErase, execFetch, lat, execAddr} = '0;
      rxPin = 1'b1;
      stackPtr = 16'($random(seed));
      for (int i = 0; i < 65536; i++)
         pm.mem[i] = 8'($random(seed));
      // stored security bytes start erased, as the unit holds them after reset
      for (int i = 0; i < 8; i++)
         pm.mem[`SMCU_SEC_BASE + 16'(i)] = `SMCU_ERASED;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      por;
      secure(1'b0);
      chk({8'h00, securityPassed}, 9'h001);
      rd(`SMCU_SEC_FLAG_ADDR, pm.mem[16'h0060] | 8'h40);
      exec(0);
      $display("test security pass done");
      d = 8'($random(seed));
      wr(16'h1234, d);
      rd(16'h1234, d);
      expq.push_back({1'b0, pm.mem[16'h1235]});
      expq.push_back({1'b0, pm.mem[16'h1236]});
      hs({1'b0, `SMCU_OP_IDX_RD});
      d = 8'($random(seed));
      hs({1'b0, `SMCU_OP_IDX_WR});
      hs({1'b0, d});
      chk({1'b0, pm.mem[16'h1237]}, {1'b0, d});
      wr(16'hffff, 8'h5a);
      hs({1'b0, `SMCU_OP_IDX_WR});
      hs({1'b0, ~d});
      chk({1'b0, pm.mem[16'h0000]}, {1'b0, ~d});
      $display("test memory access done");
      expq.push_back({1'b0, stackPtr[15:8]});
      expq.push_back({1'b0, stackPtr[7:0]});
      hs({1'b0, `SMCU_OP_STACK_RD});
      hs(9'h100);
      hs({1'b0, `SMCU_OP_RUN});
      chk(9'(runCnt), 9'h001);
      $display("test stack break run done");
      rst;
      chk({8'h00, securityPassed}, 9'h001);
      rd(16'h9000, pm.mem[16'h9000]);
      por;
      secure(1'b1);
      chk({8'h00, securityPassed}, 9'h000);
      rd(16'h9000, `SMCU_INVALID);
      exec(1);
      rst;
      chk({8'h00, securityPassed}, 9'h000);
      $display("test security fail done");
      bulkErase = 1'b1;
      @(negedge clock);
      bulkErase = 1'b0;
      chk({1'b0, pm.mem[16'hfffd]}, 9'h0ff);
      por;
      secure(1'b0);
      chk({8'h00, securityPassed}, 9'h001);
      $display("test erase retry done");
      end_sim;
   end
endmodule
